// File: lcdp_column_driver.sv
// How it works
// - Column drive levels are updated only after a falling edge of the line latch is seen.
// - A nibble is captured on each falling edge of the shift clock while the chain is enabled, except in a cycle where the latch falls.
// - After the latch falling edge, once the FIFO is empty, the collected data register is copied into the output latch.
// - Direction select high makes terminal A the enable output and B the input, low the reverse.
// - The enable output drops on the latch and rises once 80 bits have been taken in.
// - Direction high maps the first nibble MSB first from column 79 down, low mirrors it.
// - Column placement follows arrival order in the enabled window, not the raw clock count.
// - Data and polarity pick top, bottom, second or third drive level.
// - While disabled the internal shift clock and data bus are held low.
//
// Purpose: Data path of an 80-column LCD driver with cascade enable chain
// Assumes: Shift clock and latch pins are slow, synchronous levels sampled on clk
// Notes:   Latch transfer waits until the FIFO has drained into the data register

`timescale 1ns/10ps

module lcdp_column_driver
   import lcdp_pkg::*;
#(
   parameter int COLS  = COLUMNS,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [NIBBLE_W-1:0]     pixel_nibble_in,
   input  wire logic                    nibble_shift_clock,
   input  wire logic                    line_latch_pulse,
   input  wire logic                    direction_select,
   input  wire logic                    ac_polarity,
   input  wire logic                    chain_enable_a_in,
   output logic                         chain_enable_a_out,
   output logic                         chain_enable_a_oe,
   input  wire logic                    chain_enable_b_in,
   output logic                         chain_enable_b_out,
   output logic                         chain_enable_b_oe,
   output logic                         nibble_ready,
   output logic [COLS*LEVEL_W-1:0]      column_outputs
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Drive level from data bit and polarity
   function automatic lcdp_level_type level_of(input logic bit_d, input logic pol);
      lcdp_level_type lv;
      case ({bit_d, pol})
         2'b11:   lv = LVL_TOP;
         2'b10:   lv = LVL_BOTTOM;
         2'b01:   lv = LVL_SECOND;
         default: lv = LVL_THIRD;
      endcase
      return lv;
   endfunction

   // Column index of nibble bit k at fill position pos
   function automatic int col_of(input logic dir, input logic [POS_W-1:0] pos, input int k);
      int c;
      if (dir)
      begin
         c = COLS - 1 - NIBBLE_W * int'(pos) - (NIBBLE_W - 1 - k);
      end
      else
      begin
         c = NIBBLE_W * int'(pos) + (NIBBLE_W - 1 - k);
      end
      return c;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   // Fill position at which a line of COLS bits is complete
   localparam logic [POS_W-1:0] FILL_END = POS_W'(COLS / NIBBLE_W);

   lcdp_state_type            state;
   lcdp_state_type            next_state;
   logic                      shift_prev;
   logic                      latch_prev;
   logic [POS_W-1:0]          wr_count;
   logic [POS_W-1:0]          next_wr_count;
   logic [POS_W-1:0]          fill_pos;
   logic [POS_W-1:0]          next_fill_pos;
   logic [COLS-1:0]           data_reg;
   logic [COLS-1:0]           next_data_reg;
   logic [COLS*LEVEL_W-1:0]   next_column_outputs;
   logic                      next_enable_out;
   logic                      enable_in;
   logic                      enabled;
   logic                      shift_fall;
   logic                      latch_fall;
   logic                      gated_shift;
   logic [NIBBLE_W-1:0]       gated_nibble;
   logic                      cap_valid;
   logic                      fifo_in_ready;
   logic                      fifo_out_valid;
   logic [NIBBLE_W-1:0]       fifo_out_data;
   logic                      drain_ready;
   logic                      drain;
   logic                      transfer;

   // ----------------------------------------------------------------
   // Enable chain and input gating
   // ----------------------------------------------------------------
   always_comb
   begin
      enable_in    = direction_select ? chain_enable_b_in : chain_enable_a_in;
      enabled      = enable_in && (state == ST_FILL);
      gated_shift  = enabled && nibble_shift_clock;
      gated_nibble = enabled ? pixel_nibble_in : NIBBLE_ZERO;
      shift_fall   = shift_prev && !gated_shift;
      latch_fall   = latch_prev && !line_latch_pulse;
      cap_valid    = shift_fall && enabled && !latch_fall;
   end

   // ----------------------------------------------------------------
   // Line state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state      = state;
      next_wr_count   = wr_count;
      next_enable_out = chain_enable_a_out;
      transfer        = 1'b0;
      case (state)
         ST_FILL:
         begin
            if (cap_valid && fifo_in_ready)
            begin
               next_wr_count = wr_count + POS_W'(1);
               if (next_wr_count == FILL_END)
               begin
                  next_state      = ST_DONE;
                  next_enable_out = 1'b1;
               end
            end
         end
         ST_DONE:
         begin
            next_enable_out = 1'b1;
         end
         ST_FLUSH:
         begin
            next_enable_out = 1'b0;
            if (!fifo_out_valid)
            begin
               transfer      = 1'b1;
               next_wr_count = POS_RESET;
               next_state    = ST_FILL;
            end
         end
         default:
         begin
            next_state      = ST_FILL;
            next_wr_count   = POS_RESET;
            next_enable_out = 1'b0;
         end
      endcase
      if (latch_fall)
      begin
         next_state      = ST_FLUSH;
         next_enable_out = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state              <= ST_FILL;
         wr_count           <= POS_RESET;
         shift_prev         <= 1'b0;
         latch_prev         <= 1'b0;
         chain_enable_a_out <= 1'b0;
         chain_enable_b_out <= 1'b0;
         chain_enable_a_oe  <= 1'b0;
         chain_enable_b_oe  <= 1'b0;
      end
      else
      begin
         state              <= next_state;
         wr_count           <= next_wr_count;
         shift_prev         <= gated_shift;
         latch_prev         <= line_latch_pulse;
         chain_enable_a_out <= next_enable_out;
         chain_enable_b_out <= next_enable_out;
         chain_enable_a_oe  <= direction_select;
         chain_enable_b_oe  <= !direction_select;
      end
   end

   // ----------------------------------------------------------------
   // Nibble buffer
   // ----------------------------------------------------------------
   lcdp_fifo
   #(
      .WIDTH (NIBBLE_W),
      .DEPTH (DEPTH)
   )
   u_fifo
   (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (cap_valid),
      .in_data   (gated_nibble),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (drain_ready)
   );

   // ----------------------------------------------------------------
   // Data register and output latch
   // ----------------------------------------------------------------
   always_comb
   begin
      drain_ready         = (fill_pos != FILL_END) && !transfer;
      drain               = fifo_out_valid && drain_ready;
      next_fill_pos       = fill_pos;
      next_data_reg       = data_reg;
      next_column_outputs = column_outputs;
      if (drain)
      begin
         for (int k = 0; k < NIBBLE_W; k++)
         begin
            next_data_reg[col_of(direction_select, fill_pos, k)] = fifo_out_data[k];
         end
         next_fill_pos = fill_pos + POS_W'(1);
      end
      if (transfer)
      begin
         next_fill_pos = POS_RESET;
         for (int c = 0; c < COLS; c++)
         begin
            next_column_outputs[c*LEVEL_W +: LEVEL_W] =
               level_of(data_reg[c], ac_polarity);
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fill_pos       <= POS_RESET;
         data_reg       <= '0;
         column_outputs <= '0;
         nibble_ready   <= 1'b0;
      end
      else
      begin
         fill_pos       <= next_fill_pos;
         data_reg       <= next_data_reg;
         column_outputs <= next_column_outputs;
         nibble_ready   <= fifo_in_ready && (next_state == ST_FILL);
      end
   end

endmodule

// File: lcdp_ctl_model.sv
// Purpose: Display controller model driving nibbles, shift clock, latch, polarity
// Assumes: Tasks are called by the bench
// Notes:   Data is inverted once its hold time has run out
`timescale 1ns/10ps
module lcdp_ctl_model
   import lcdp_pkg::*;
(
   input  wire logic           clk,
   output logic [NIBBLE_W-1:0] pixel_nibble_in,
   output logic                nibble_shift_clock,
   output logic                line_latch_pulse,
   output logic                ac_polarity
);
   initial
   begin
      pixel_nibble_in = 4'h0;
      nibble_shift_clock = 1'b0;
      line_latch_pulse = 1'b0;
      ac_polarity = 1'b0;
   end
   task automatic send_nibble(input logic [NIBBLE_W-1:0] n);
   begin
      @(posedge clk) #1;
      pixel_nibble_in = n;
      nibble_shift_clock = 1'b1;
      repeat (2) @(posedge clk);
      #1 nibble_shift_clock = 1'b0;
      repeat (2) @(posedge clk);
      #1 pixel_nibble_in = ~n;
   end
   endtask
   task automatic latch_line(input logic pol);
   begin
      @(posedge clk) #1;
      line_latch_pulse = 1'b1;
      ac_polarity = pol;
      repeat (2) @(posedge clk);
      #1 line_latch_pulse = 1'b0;
      repeat (14) @(posedge clk);
      #1;
   end
   endtask
endmodule

// File: lcdp_fifo.sv
// Purpose: Small FIFO between nibble capture and the data register
// Assumes: DEPTH is a power of two
// Notes:   Read data, valid and ready all come from flip-flops

`timescale 1ns/10ps

module lcdp_fifo
#(
   parameter int WIDTH = 4,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [CW-1:0]    next_count;
   logic [WIDTH-1:0] next_out_data;
   logic             do_wr;
   logic             do_rd;

   // ----------------------------------------------------------------
   // Pointer and count update
   // ----------------------------------------------------------------
   always_comb
   begin
      do_wr       = in_valid && in_ready;
      do_rd       = out_valid && out_ready;
      next_wr_ptr = do_wr ? wr_ptr + AW'(1) : wr_ptr;
      next_rd_ptr = do_rd ? rd_ptr + AW'(1) : rd_ptr;
      next_count  = count;
      if (do_wr && !do_rd)
      begin
         next_count = count + CW'(1);
      end
      else if (do_rd && !do_wr)
      begin
         next_count = count - CW'(1);
      end
      // Bypass when the head slot is written this cycle
      if (do_wr && (wr_ptr == next_rd_ptr))
      begin
         next_out_data = in_data;
      end
      else
      begin
         next_out_data = mem[next_rd_ptr];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         out_valid <= 1'b0;
         in_ready  <= 1'b0;
         out_data  <= '0;
      end
      else
      begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         count     <= next_count;
         out_valid <= (next_count != '0);
         in_ready  <= (next_count != CW'(DEPTH));
         out_data  <= next_out_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (do_wr)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule

// File: lcdp_monitor.sv
// Purpose: Port assertions for the column driver
// Assumes: Latch stays low at least 12 cycles after each fall
// Notes:   Bound to every column driver instance
`timescale 1ns/10ps
module lcdp_monitor
   import lcdp_pkg::*;
#(
   parameter int COLS = COLUMNS
)
(
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic [NIBBLE_W-1:0]  pixel_nibble_in,
   input wire logic                 nibble_shift_clock,
   input wire logic                 line_latch_pulse,
   input wire logic                 direction_select,
   input wire logic                 ac_polarity,
   input wire logic                 chain_enable_a_in,
   input wire logic                 chain_enable_a_out,
   input wire logic                 chain_enable_a_oe,
   input wire logic                 chain_enable_b_in,
   input wire logic                 chain_enable_b_out,
   input wire logic                 chain_enable_b_oe,
   input wire logic                 nibble_ready,
   input wire logic [COLS*LEVEL_W-1:0] column_outputs
);
   logic       shift_prev, latch_prev, fall_now, en_in, lvl_hi, lvl_lo;
   logic       next_shift_prev, next_latch_prev;
   logic [4:0] since_fall, next_since_fall;
   logic [5:0] taken, next_taken;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   always_comb
   begin
      fall_now = latch_prev & ~line_latch_pulse;
      en_in = direction_select ? chain_enable_b_in : chain_enable_a_in;
      next_shift_prev = nibble_shift_clock;
      next_latch_prev = line_latch_pulse;
      next_since_fall = fall_now ? 5'h0_0 : since_fall + {4'h0, since_fall != 5'h1_F};
      next_taken = taken;
      if (fall_now)
         next_taken = 6'h0_0;
      else if (shift_prev & ~nibble_shift_clock & en_in & (taken != 6'h3_F))
         next_taken = taken + 6'h0_1;
      lvl_hi = 1'b1;
      lvl_lo = 1'b1;
      for (int c = 0; c < COLS; c++)
      begin
         lvl_hi = lvl_hi & ~column_outputs[2*c+1];
         lvl_lo = lvl_lo & column_outputs[2*c+1];
      end
   end
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         shift_prev <= 1'b0;
         latch_prev <= 1'b0;
         since_fall <= 5'h1_F;
         taken <= 6'h0_0;
      end
      else
      begin
         shift_prev <= next_shift_prev;
         latch_prev <= next_latch_prev;
         since_fall <= next_since_fall;
         taken <= next_taken;
      end
   a_oe_follows_dir: assert property (!$past(rst) |-> chain_enable_a_oe == $past(direction_select)
      && chain_enable_b_oe == !$past(direction_select)) else $error("enable pin direction wrong");
   a_enable_same: assert property (chain_enable_a_out == chain_enable_b_out)
      else $error("enable outputs differ");
   a_enable_drop: assert property (fall_now |-> ##[1:2] !chain_enable_a_out)
      else $error("enable out not cleared by latch");
   a_enable_hold: assert property (chain_enable_a_out && !fall_now |=> chain_enable_a_out)
      else $error("enable out fell without latch");
   a_enable_rise: assert property ($rose(chain_enable_a_out) |-> taken >= 20)
      else $error("enable out rose before line full");
   a_enable_full: assert property (taken >= 20 && $past(taken, 3) >= 20 |-> chain_enable_a_out)
      else $error("enable out missing after full line");
   a_cols_on_latch: assert property ($changed(column_outputs) |-> since_fall <= 12)
      else $error("columns changed without latch");
   a_level_polarity: assert property ($changed(column_outputs) |-> (ac_polarity ? lvl_hi : lvl_lo))
      else $error("drive level does not match polarity");
endmodule
bind lcdp_column_driver lcdp_monitor #(.COLS(COLS)) u_monitor (.clk(clk), .rst(rst),
   .pixel_nibble_in(pixel_nibble_in), .nibble_shift_clock(nibble_shift_clock),
   .line_latch_pulse(line_latch_pulse), .direction_select(direction_select),
   .ac_polarity(ac_polarity), .chain_enable_a_in(chain_enable_a_in),
   .chain_enable_a_out(chain_enable_a_out), .chain_enable_a_oe(chain_enable_a_oe),
   .chain_enable_b_in(chain_enable_b_in), .chain_enable_b_out(chain_enable_b_out),
   .chain_enable_b_oe(chain_enable_b_oe), .nibble_ready(nibble_ready),
   .column_outputs(column_outputs));

// File: lcdp_pkg.sv
// Purpose: Shared constants and types for the LCD column driver data path
// Assumes: One 10 MHz system clock; all pins synchronous to it
// Notes:   Drive levels are carried as a 2-bit code per column

package lcdp_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int COLUMNS          = 80;
   localparam int NIBBLE_W         = 4;
   localparam int NIBBLES_PER_LINE = COLUMNS / NIBBLE_W;
   localparam int POS_W            = 5;
   localparam int FIFO_DEPTH       = 8;
   localparam int LEVEL_W          = 2;

   // ----------------------------------------------------------------
   // Reset values and line length
   // ----------------------------------------------------------------
   localparam logic [POS_W-1:0]    POS_RESET    = 5'h0_0;
   localparam logic [NIBBLE_W-1:0] NIBBLE_ZERO  = 4'h0;
   localparam logic [POS_W-1:0]    LINE_NIBBLES = 5'h1_4;

   // ----------------------------------------------------------------
   // Drive level codes
   // ----------------------------------------------------------------
   typedef enum logic [LEVEL_W-1:0]
   {
      LVL_TOP    = 2'h0,
      LVL_SECOND = 2'h1,
      LVL_THIRD  = 2'h2,
      LVL_BOTTOM = 2'h3
   } lcdp_level_type;

   // ----------------------------------------------------------------
   // Line fill states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_FILL  = 3'h1,
      ST_DONE  = 3'h2,
      ST_FLUSH = 3'h4
   } lcdp_state_type;

endpackage

// File: testbench.sv
// Purpose: Self-checking bench for the column driver
// Assumes: Controller model drives the display side
// Notes:   Column results are compared from a queue of expected lines
`timescale 1ns/10ps
module testbench;
   import lcdp_pkg::*;
   logic clk, rst, dir, en_src, a_in, a_out, a_oe, b_in, b_out, b_oe, ready, shift, latch, pol;
   logic [NIBBLE_W-1:0]        nibble;
   logic [COLUMNS*LEVEL_W-1:0] cols, last_cols;
   logic [COLUMNS*LEVEL_W-1:0] exp_q[$];
   logic [COLUMNS-1:0]         bits;
   logic [31:0]                seed;
   int                         failures, total_checks, cycles;
   assign a_in = a_oe ? a_out : en_src;
   assign b_in = b_oe ? b_out : en_src;
   lcdp_ctl_model u_ctl (.clk(clk), .pixel_nibble_in(nibble), .nibble_shift_clock(shift),
      .line_latch_pulse(latch), .ac_polarity(pol));
   lcdp_column_driver u_dut (.clk(clk), .rst(rst), .pixel_nibble_in(nibble),
      .nibble_shift_clock(shift), .line_latch_pulse(latch), .direction_select(dir),
      .ac_polarity(pol), .chain_enable_a_in(a_in), .chain_enable_a_out(a_out),
      .chain_enable_a_oe(a_oe), .chain_enable_b_in(b_in), .chain_enable_b_out(b_out),
      .chain_enable_b_oe(b_oe), .nibble_ready(ready), .column_outputs(cols));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [COLUMNS*LEVEL_W-1:0] expect_cols(input logic p);
      logic [COLUMNS*LEVEL_W-1:0] r;
      for (int c = 0; c < COLUMNS; c++)
         r[2*c +: 2] = bits[c] ? (p ? LVL_TOP : LVL_BOTTOM) : (p ? LVL_SECOND : LVL_THIRD);
      return r;
   endfunction
   task automatic check(input string name, input logic [COLUMNS*LEVEL_W-1:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report;
      if (failures == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic run_line(input logic d, input logic p, input int pre, input int extra);
      logic [NIBBLE_W-1:0] n;
      @(posedge clk) #1;
      dir = d;
      en_src = 1'b0;
      repeat (2) @(posedge clk);
      check("enable a oe", a_oe, d);
      check("enable b oe", b_oe, !d);
      for (int i = 0; i < pre; i++)
      begin
         seed = xs(seed);
         u_ctl.send_nibble(seed[3:0]);
      end
      en_src = 1'b1;
      for (int i = 0; i < 20 + extra; i++)
      begin
         seed = xs(seed);
         n = seed[3:0];
         for (int k = 0; k < 4 && i < 20; k++)
            bits[d ? 79 - 4*i - (3-k) : 4*i + (3-k)] = n[k];
         u_ctl.send_nibble(n);
      end
      repeat (3) @(posedge clk);
      check("enable out full", d ? a_out : b_out, 1'b1);
      check("nibble ready full", ready, 1'b0);
      exp_q.push_back(expect_cols(p));
      u_ctl.latch_line(p);
      check("enable out latched", d ? a_out : b_out, 1'b0);
      check("nibble ready relatched", ready, 1'b1);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         final_report;
      end
   end
   always @(negedge clk)
      if (!rst && cols !== last_cols)
      begin
         check("column outputs", cols, exp_q.size() != 0 ? exp_q.pop_front() : last_cols);
         last_cols = cols;
      end
   initial
   begin
      rst = 1'b1;
      dir = 1'b1;
      en_src = 1'b0;
      seed = 32'h0000_003C;
      last_cols = '0;
      bits = '0;
      failures = 0;
      total_checks = 0;
      cycles = 0;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      check("reset columns", cols, '0);
      run_line(1'b1, 1'b1, 0, 0);
      run_line(1'b1, 1'b0, 3, 2);
      run_line(1'b0, 1'b1, 2, 0);
      run_line(1'b0, 1'b0, 0, 1);
      repeat (5) @(posedge clk);
      check("pending lines", exp_q.size(), 0);
      final_report;
   end
endmodule
